// ### dv/sgoc_breaker_model.sv
`default_nettype none
module sgoc_breaker_model (
  input wire logic clock_i,
  input wire logic open_cmd_i,
  input wire logic close_cmd_i,
  input wire logic [3:0] delay_i,
  output logic open_in_o,
  output logic close_in_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic closed = 1'b0;
  logic moving = 1'b0;
  logic [3:0] cnt = 4'h0;
  // Travel, once started, always completes
  always_ff @(posedge clock_i) begin
    if (!moving && ((open_cmd_i && closed) || (close_cmd_i && !closed))) begin
      moving <= 1'b1;
      cnt <= 4'h0;
    end else if (moving) begin
      cnt <= cnt + 4'h1;
      if (cnt == delay_i) begin
        moving <= 1'b0;
        closed <= !closed;
      end
    end
  end
  assign open_in_o = !closed && !moving;
  assign close_in_o = closed && !moving;
endmodule : sgoc_breaker_model
`default_nettype wire

// ### dv/switchgear_object_control_tb_top.sv
`default_nettype none
module switchgear_object_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 0, rst_i = 1, ovr = 1, f_open = 0, f_close = 0, use_sync = 0;
  logic cin = 0, cout = 0, rdy = 0, sync = 0, oreq = 0, creq = 0, clr = 0;
  logic m_open, m_close, ocmd, ccmd, busy;
  logic [3:0] dly = 4'h3;
  logic [31:0] lfsr = 32'h4a536bb1;
  int failures = 0, n_checks = 0, cyc = 0;
  sgoc_pkg::sgoc_obj_type otype = sgoc_pkg::SGOC_WDBRK;
  sgoc_pkg::sgoc_rdy_type urdy = sgoc_pkg::SGOC_RDY_OFF;
  sgoc_pkg::sgoc_pos_type bpos, cpos;
  sgoc_pkg::sgoc_aux_type aux;
  sgoc_pkg::sgoc_cnt_type cnt, prev, e;
  sgoc_pkg::sgoc_cnt_type q[$];
  sgoc_object #(.PULSE_CYCLES(20), .TERM_CYCLES(100)) u_sgoc_object (.clock_i(clock_i),
    .rst_i(rst_i), .obj_type_i(otype), .use_sync_i(use_sync), .use_ready_i(urdy),
    .open_in_i(ovr ? f_open : m_open), .close_in_i(ovr ? f_close : m_close),
    .cart_in_input_i(cin), .cart_out_input_i(cout), .ready_in_i(rdy), .sync_in_i(sync),
    .open_req_i(oreq), .close_req_i(creq), .clear_stats_i(clr), .open_cmd_o(ocmd),
    .close_cmd_o(ccmd), .breaker_pos_o(bpos), .cart_pos_o(cpos), .aux_o(aux),
    .cnt_o(cnt), .clear_busy_o(busy));
  sgoc_breaker_model u_sgoc_breaker_model (.clock_i(clock_i), .open_cmd_i(ocmd),
    .close_cmd_i(ccmd), .delay_i(dly), .open_in_o(m_open), .close_in_o(m_close));
  function automatic logic [31:0] next_rand(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : next_rand
  function automatic sgoc_pkg::sgoc_pos_type dec(input logic a, input logic b);
    return (a && b) ? sgoc_pkg::SGOC_POS_FAULT : a ? sgoc_pkg::SGOC_POS_OPEN
      : b ? sgoc_pkg::SGOC_POS_CLOSED : sgoc_pkg::SGOC_POS_BETWEEN;
  endfunction : dec
  task automatic check(input string n, input logic [127:0] s, input logic [127:0] x);
    n_checks++;
    if (s !== x) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask : check
  task automatic results;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  task automatic settle(input int n);
    repeat (n) @(negedge clock_i);
  endtask : settle
  // One request, expected count noted before it is made
  task automatic req(input logic op, input logic ok);
    int t = 0;
    case ({op, ok})
      2'b11: e.open_ok++;
      2'b10: e.open_fail++;
      2'b01: e.close_ok++;
      default: e.close_fail++;
    endcase
    q.push_back(e);
    oreq = op;
    creq = !op;
    @(negedge clock_i);
    oreq = 0;
    creq = 0;
    @(negedge clock_i);
    check(op ? "open_cmd_o" : "close_cmd_o", op ? ocmd : ccmd, ok);
    while (q.size() > 0 && t < 300) begin
      @(negedge clock_i);
      t++;
    end
    check("queue", q.size(), 0);
    check("cmd_end", ocmd | ccmd, 0);
    settle(4);
  endtask : req
  initial begin
    forever #5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end
  // Result watcher: each counter change takes the oldest note
  always @(posedge clock_i) begin
    prev <= cnt;
    if (!rst_i && cnt !== prev) begin
      if (q.size() == 0) check("cnt_o", cnt, prev);
      else check("cnt_o", cnt, q.pop_front());
    end
  end
  initial begin
    settle(4);
    rst_i = 0;
    for (int t = 0; t < 8; t++) begin
      otype = t[2] ? sgoc_pkg::SGOC_BRK : sgoc_pkg::SGOC_WDBRK;
      {f_open, f_close} = t[1:0];
      {cin, cout} = t[1:0];
      settle(6);
      check("breaker_pos_o", bpos, dec(f_open, f_close));
      check("cart_pos_o", cpos, t[2] ? sgoc_pkg::SGOC_POS_UNUSED : dec(cout, cin));
    end
    $display("test decode done");
    {cin, cout} = 2'b10;
    otype = sgoc_pkg::SGOC_WDBRK;
    ovr = 0;
    e = '0;
    settle(8);
    repeat (3) begin
      lfsr = next_rand(lfsr);
      dly = lfsr[3:0];
      rdy = lfsr[4];
      settle(6);
      req(0, 1);
      req(1, 1);
    end
    use_sync = 1;
    settle(6);
    check("aux_close_blocked", aux.close_blocked, 1);
    check("aux_sync_ok", aux.sync_ok, 0);
    check("aux_open_blocked", aux.open_blocked, 0);
    req(0, 0);
    sync = 1;
    for (int t = 0; t < 4; t++) begin
      urdy = t[1] ? sgoc_pkg::SGOC_RDY_LOW : sgoc_pkg::SGOC_RDY_HIGH;
      rdy = t[0];
      settle(6);
      check("aux_ready", aux.ready, rdy ^ t[1]);
      req(0, rdy ^ t[1]);
      if (rdy ^ t[1]) req(1, 1);
    end
    urdy = sgoc_pkg::SGOC_RDY_OFF;
    sync = 0;
    otype = sgoc_pkg::SGOC_DISC_MC;
    settle(6);
    req(0, 1);
    req(1, 1);
    otype = sgoc_pkg::SGOC_DISC_GND;
    settle(2);
    check("aux_open_blocked", aux.open_blocked, 1);
    req(1, 0);
    req(0, 0);
    $display("test control done");
    // Stuck open status: pulse ends at its limit, request times out
    ovr = 1;
    {f_open, f_close} = 2'b10;
    otype = sgoc_pkg::SGOC_BRK;
    use_sync = 0;
    settle(6);
    e.close_fail++;
    q.push_back(e);
    creq = 1;
    @(negedge clock_i);
    creq = 0;
    settle(19);
    check("close_cmd_o", ccmd, 1);
    settle(1);
    check("close_cmd_o", ccmd, 0);
    settle(80);
    check("queue", q.size(), 1);
    settle(5);
    check("queue", q.size(), 0);
    $display("test timeout done");
    e = '0;
    q.push_back(e);
    clr = 1;
    @(negedge clock_i);
    clr = 0;
    check("clear_busy_o", busy, 1);
    @(negedge clock_i);
    check("clear_busy_o", busy, 0);
    settle(4);
    check("queue", q.size(), 0);
    $display("test clear done");
    results();
  end
endmodule : switchgear_object_control_tb_top
`default_nettype wire

// ### hdl/sgoc_object.sv
`default_nettype none
module sgoc_object #(
  parameter longint unsigned PULSE_CYCLES = sgoc_pkg::PULSE_CYC,
  parameter longint unsigned TERM_CYCLES = sgoc_pkg::TERM_CYC
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire sgoc_pkg::sgoc_obj_type obj_type_i,
  input wire logic use_sync_i,
  input wire sgoc_pkg::sgoc_rdy_type use_ready_i,
  input wire logic open_in_i,
  input wire logic close_in_i,
  input wire logic cart_in_input_i,
  input wire logic cart_out_input_i,
  input wire logic ready_in_i,
  input wire logic sync_in_i,
  input wire logic open_req_i,
  input wire logic close_req_i,
  input wire logic clear_stats_i,
  output logic open_cmd_o,
  output logic close_cmd_o,
  output sgoc_pkg::sgoc_pos_type breaker_pos_o,
  output sgoc_pkg::sgoc_pos_type cart_pos_o,
  output sgoc_pkg::sgoc_aux_type aux_o,
  output sgoc_pkg::sgoc_cnt_type cnt_o,
  output logic clear_busy_o
);
  // ==========================================================
  // Input synchronisers
  // ==========================================================
  localparam int NIN = 6;
  logic [NIN-1:0] pin_raw;
  logic [NIN-1:0] s1, s2, s3, pin;
  assign pin_raw = {sync_in_i, ready_in_i, cart_out_input_i, cart_in_input_i,
                    close_in_i, open_in_i};
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_sync
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          s1[gi] <= 1'b0;
          s2[gi] <= 1'b0;
          s3[gi] <= 1'b0;
          pin[gi] <= 1'b0;
        end else begin
          s1[gi] <= pin_raw[gi];
          s2[gi] <= s1[gi];
          s3[gi] <= s2[gi];
          if (s2[gi] == s3[gi]) begin
            pin[gi] <= s3[gi];
          end
        end
      end
    end
  endgenerate
  logic st_open, st_close, st_cin, st_cout, st_rdy, st_sync;
  assign {st_sync, st_rdy, st_cout, st_cin, st_close, st_open} = pin;

  // ==========================================================
  // Position decoding
  // ==========================================================
  sgoc_pkg::sgoc_pos_type next_brk, next_cart;
  always_comb begin
    unique case ({st_close, st_open})
      2'b00: next_brk = sgoc_pkg::SGOC_POS_BETWEEN;
      2'b01: next_brk = sgoc_pkg::SGOC_POS_OPEN;
      2'b10: next_brk = sgoc_pkg::SGOC_POS_CLOSED;
      2'b11: next_brk = sgoc_pkg::SGOC_POS_FAULT;
    endcase
    if (obj_type_i != sgoc_pkg::SGOC_WDBRK) begin
      next_cart = sgoc_pkg::SGOC_POS_UNUSED;
    end else begin
      unique case ({st_cout, st_cin})
        2'b00: next_cart = sgoc_pkg::SGOC_POS_BETWEEN;
        2'b01: next_cart = sgoc_pkg::SGOC_POS_CLOSED;
        2'b10: next_cart = sgoc_pkg::SGOC_POS_OPEN;
        2'b11: next_cart = sgoc_pkg::SGOC_POS_FAULT;
      endcase
    end
  end
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      breaker_pos_o <= sgoc_pkg::SGOC_POS_BETWEEN;
      cart_pos_o <= sgoc_pkg::SGOC_POS_UNUSED;
    end else begin
      breaker_pos_o <= next_brk;
      cart_pos_o <= next_cart;
    end
  end

  // ==========================================================
  // Close conditions and status flags
  // ==========================================================
  logic is_brk, can_ctrl, rdy_ok, sync_ok, close_ok;
  assign is_brk = (obj_type_i == sgoc_pkg::SGOC_WDBRK) || (obj_type_i == sgoc_pkg::SGOC_BRK);
  assign can_ctrl = (obj_type_i != sgoc_pkg::SGOC_DISC_GND);
  assign rdy_ok = !is_brk || (use_ready_i == sgoc_pkg::SGOC_RDY_OFF) ||
                  ((use_ready_i == sgoc_pkg::SGOC_RDY_HIGH) && st_rdy) ||
                  ((use_ready_i == sgoc_pkg::SGOC_RDY_LOW) && !st_rdy);
  assign sync_ok = !is_brk || !use_sync_i || st_sync;
  assign close_ok = can_ctrl && rdy_ok && sync_ok;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      aux_o <= '0;
    end else begin
      aux_o.open_blocked <= !can_ctrl;
      aux_o.close_blocked <= !close_ok;
      aux_o.ready <= rdy_ok;
      aux_o.sync_ok <= sync_ok;
    end
  end

  // ==========================================================
  // Command sequencer
  // ==========================================================
  typedef enum logic [1:0] {SGOC_IDLE, SGOC_OPENING, SGOC_CLOSING} sgoc_state_type;
  sgoc_state_type state;
  logic [39:0] tmr;
  logic ev_open_ok, ev_close_ok, ev_open_fail, ev_close_fail;
  logic start_pos_open, start_pos_closed;
  logic reached, changed;
  assign reached = (state == SGOC_OPENING) ? (st_open && !st_close) : (st_close && !st_open);
  assign changed = (st_open != start_pos_open) || (st_close != start_pos_closed);
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state <= SGOC_IDLE;
      tmr <= 40'h0;
      open_cmd_o <= 1'b0;
      close_cmd_o <= 1'b0;
      start_pos_open <= 1'b0;
      start_pos_closed <= 1'b0;
      ev_open_ok <= 1'b0;
      ev_close_ok <= 1'b0;
      ev_open_fail <= 1'b0;
      ev_close_fail <= 1'b0;
    end else begin
      ev_open_ok <= 1'b0;
      ev_close_ok <= 1'b0;
      ev_open_fail <= 1'b0;
      ev_close_fail <= 1'b0;
      unique case (state)
        SGOC_IDLE: begin
          tmr <= 40'h0;
          start_pos_open <= st_open;
          start_pos_closed <= st_close;
          if (open_req_i) begin
            if (can_ctrl) begin
              state <= SGOC_OPENING;
              open_cmd_o <= 1'b1;
            end else begin
              ev_open_fail <= 1'b1;
            end
          end else if (close_req_i) begin
            if (close_ok) begin
              state <= SGOC_CLOSING;
              close_cmd_o <= 1'b1;
            end else begin
              ev_close_fail <= 1'b1;
            end
          end
        end
        SGOC_OPENING, SGOC_CLOSING: begin
          tmr <= tmr + 40'h1;
          if (changed || tmr >= 40'(PULSE_CYCLES - 1)) begin
            open_cmd_o <= 1'b0;
            close_cmd_o <= 1'b0;
          end
          if (reached) begin
            state <= SGOC_IDLE;
            open_cmd_o <= 1'b0;
            close_cmd_o <= 1'b0;
            ev_open_ok <= (state == SGOC_OPENING);
            ev_close_ok <= (state == SGOC_CLOSING);
          end else if (tmr >= 40'(TERM_CYCLES - 1)) begin
            state <= SGOC_IDLE;
            open_cmd_o <= 1'b0;
            close_cmd_o <= 1'b0;
            ev_open_fail <= (state == SGOC_OPENING);
            ev_close_fail <= (state == SGOC_CLOSING);
          end
        end
        default: state <= SGOC_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Request statistics
  // ==========================================================
  logic [3:0] ev;
  logic [31:0] cnt [4];
  assign ev = {ev_open_ok, ev_close_ok, ev_open_fail, ev_close_fail};
  generate
    for (gi = 0; gi < 4; gi++) begin : g_cnt
      always_ff @(posedge clock_i) begin
        if (rst_i || clear_stats_i) begin
          cnt[gi] <= sgoc_pkg::CNT_RESET;
        end else if (ev[gi] && cnt[gi] != sgoc_pkg::CNT_MAX) begin
          cnt[gi] <= cnt[gi] + 32'h1;
        end
      end
    end
  endgenerate
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cnt_o <= '0;
      clear_busy_o <= 1'b0;
    end else begin
      cnt_o <= {cnt[3], cnt[2], cnt[1], cnt[0]};
      clear_busy_o <= clear_stats_i;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  sequence cmd_idle_s;
    !open_cmd_o && !close_cmd_o;
  endsequence
  sequence close_refused_s;
    !close_cmd_o && ev_close_fail;
  endsequence
  cart_fault_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (obj_type_i == sgoc_pkg::SGOC_WDBRK && st_cin && st_cout)
    |=> cart_pos_o == sgoc_pkg::SGOC_POS_FAULT)
    else $error("cart fault not shown");
  cart_unused_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (obj_type_i != sgoc_pkg::SGOC_WDBRK) |=> cart_pos_o == sgoc_pkg::SGOC_POS_UNUSED)
    else $error("cart not marked unused");
  sync_gate_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (state == SGOC_IDLE && !open_req_i && close_req_i && is_brk && use_sync_i && !st_sync)
    |=> !close_cmd_o && ev_close_fail)
    else $error("close passed without sync");
  gnd_nocmd_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (obj_type_i == sgoc_pkg::SGOC_DISC_GND && state == SGOC_IDLE) |=> !open_cmd_o && !close_cmd_o)
    else $error("command on earthing switch");
  clear_zero_a: assert property (@(posedge clock_i) disable iff (rst_i)
    clear_stats_i |=> ##1 cnt_o == '0)
    else $error("counters not cleared");
  pulse_stop_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (state == SGOC_CLOSING && close_cmd_o && changed) |=> !close_cmd_o)
    else $error("close pulse not ended on change");
  sat_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (cnt[0] == sgoc_pkg::CNT_MAX && !clear_stats_i) |=> cnt[0] == sgoc_pkg::CNT_MAX)
    else $error("counter wrapped");
  open_pulse_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (state == SGOC_IDLE && open_req_i && can_ctrl) |=> open_cmd_o && state == SGOC_OPENING)
    else $error("open pulse missing");
  close_pulse_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (state == SGOC_IDLE && !open_req_i && close_req_i && close_ok)
    |=> close_cmd_o && state == SGOC_CLOSING)
    else $error("close pulse missing");
  ready_gate_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (state == SGOC_IDLE && !open_req_i && close_req_i && is_brk &&
     ((use_ready_i == sgoc_pkg::SGOC_RDY_HIGH && !st_rdy) ||
      (use_ready_i == sgoc_pkg::SGOC_RDY_LOW && st_rdy))) |=> close_refused_s)
    else $error("close passed while not ready");
  gnd_refuse_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (obj_type_i == sgoc_pkg::SGOC_DISC_GND && state == SGOC_IDLE && open_req_i)
    |=> !open_cmd_o && ev_open_fail)
    else $error("earthing switch open not refused");
  pulse_max_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (state != SGOC_IDLE && tmr >= 40'(PULSE_CYCLES - 1)) |=> cmd_idle_s)
    else $error("command pulse too long");
  term_fail_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (state == SGOC_CLOSING && !reached && tmr >= 40'(TERM_CYCLES - 1))
    |=> state == SGOC_IDLE && ev_close_fail)
    else $error("close timeout not counted");
  brk_fault_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (st_open && st_close) |=> breaker_pos_o == sgoc_pkg::SGOC_POS_FAULT)
    else $error("breaker fault not shown");
  cart_between_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (obj_type_i == sgoc_pkg::SGOC_WDBRK && !st_cin && !st_cout)
    |=> cart_pos_o == sgoc_pkg::SGOC_POS_BETWEEN)
    else $error("cart between not shown");
  busy_set_a: assert property (@(posedge clock_i) disable iff (rst_i)
    clear_stats_i |=> clear_busy_o)
    else $error("clear busy missing");
  busy_idle_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !clear_stats_i |=> !clear_busy_o)
    else $error("clear control not back to idle");
  open_count_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (ev_open_ok && !clear_stats_i && cnt[3] != sgoc_pkg::CNT_MAX)
    |=> cnt[3] == $past(cnt[3]) + 32'h1)
    else $error("open count not stepped");
endmodule : sgoc_object
`default_nettype wire

// ### hdl/sgoc_pkg.sv
`default_nettype none
package sgoc_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  // Command pulse length and termination timeout in milliseconds
  localparam int unsigned PULSE_MS = 200;
  localparam int unsigned TERM_MS = 10_000;
  localparam longint unsigned PULSE_CYC = longint'(PULSE_MS) * CLK_HZ / 1000;
  localparam longint unsigned TERM_CYC = longint'(TERM_MS) * CLK_HZ / 1000;
  localparam logic [31:0] CNT_RESET = 32'h0000_0000;
  localparam logic [31:0] CNT_MAX = 32'hffff_ffff;

  typedef enum logic [1:0] {
    SGOC_WDBRK,
    SGOC_BRK,
    SGOC_DISC_MC,
    SGOC_DISC_GND
  } sgoc_obj_type;

  typedef enum logic [1:0] {
    SGOC_RDY_OFF,
    SGOC_RDY_HIGH,
    SGOC_RDY_LOW
  } sgoc_rdy_type;

  typedef enum logic [2:0] {
    SGOC_POS_BETWEEN,
    SGOC_POS_OPEN,
    SGOC_POS_CLOSED,
    SGOC_POS_FAULT,
    SGOC_POS_UNUSED
  } sgoc_pos_type;

  typedef struct packed {
    logic open_blocked;
    logic close_blocked;
    logic ready;
    logic sync_ok;
  } sgoc_aux_type;

  typedef struct packed {
    logic [31:0] open_ok;
    logic [31:0] close_ok;
    logic [31:0] open_fail;
    logic [31:0] close_fail;
  } sgoc_cnt_type;
endpackage : sgoc_pkg
`default_nettype wire
